// ---- cfr_pkg.sv ----
package cfr_pkg;
  localparam int          CFR_NREG        = 32;
  localparam int          CFR_DW          = 8;
  localparam logic [15:0] CFR_IO_OFFSET   = 16'h0020;
  localparam logic [15:0] CFR_IO_LAST     = 16'h003f;
  localparam logic [15:0] CFR_EXT_IO_BASE = 16'h0060;
  localparam logic [15:0] CFR_SPL_ADDR    = 16'h005d;
  localparam logic [15:0] CFR_HI_STEP     = 16'h0001;
  localparam logic [15:0] CFR_FLAGS_ADDR  = 16'h005f;
  localparam logic [15:0] CFR_SP_RESET    = 16'h08ff;
  localparam logic [15:0] CFR_SP_MASK     = 16'h0fff;
  localparam logic [7:0]  CFR_FLAGS_RESET = 8'h00;
  localparam int          CFR_BIT_I = 7;
  localparam int          CFR_BIT_T = 6;
  localparam int          CFR_BIT_H = 5;
  localparam int          CFR_BIT_S = 4;
  localparam int          CFR_BIT_V = 3;
  localparam int          CFR_BIT_N = 2;
  localparam int          CFR_BIT_Z = 1;
  localparam int          CFR_BIT_C = 0;
  localparam logic [4:0]  CFR_PTR_X = 5'h1a;
  localparam logic [4:0]  CFR_PTR_Y = 5'h1c;
  localparam logic [4:0]  CFR_PTR_Z = 5'h1e;

  typedef enum logic [2:0] {
    CFR_SP_HOLD, CFR_SP_PUSH1, CFR_SP_POP1, CFR_SP_PUSH2, CFR_SP_POP2
  } cfr_sp_op_t;

  typedef enum logic [1:0] {
    CFR_PTR_PLAIN, CFR_PTR_DISP, CFR_PTR_POSTINC, CFR_PTR_PREDEC
  } cfr_ptr_mode_t;

  typedef enum logic [3:0] {
    CFR_ALU_ADD, CFR_ALU_ADC, CFR_ALU_SUB, CFR_ALU_SBC, CFR_ALU_AND,
    CFR_ALU_OR, CFR_ALU_EOR, CFR_ALU_MOV, CFR_ALU_INC, CFR_ALU_DEC
  } cfr_alu_op_t;
endpackage

// ---- cfr_alu.sv ----
`timescale 1ns/1ps
module cfr_alu
  import cfr_pkg::*;
(
  input  cfr_alu_op_t op,
  input  wire logic [7:0] a,
  input  wire logic [7:0] b,
  input  wire logic [7:0] flags_in,
  output logic [7:0]      result,
  output logic [7:0]      flags_out
);
  logic [8:0] sum;
  logic [4:0] nib;
  logic       c_in;
  logic       is_arith;
  logic       is_sub;
  logic       v;
  logic       n;

  always_comb begin
    c_in     = 1'b0;
    is_arith = 1'b1;
    is_sub   = 1'b0;
    sum      = 9'h000;
    nib      = 5'h00;
    result   = 8'h00;
    case (op)
      CFR_ALU_ADD, CFR_ALU_ADC: begin
        c_in = (op == CFR_ALU_ADC) ? flags_in[CFR_BIT_C] : 1'b0;
        sum  = {1'b0, a} + {1'b0, b} + {8'h00, c_in};
        nib  = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, c_in};
      end
      CFR_ALU_SUB, CFR_ALU_SBC: begin
        is_sub = 1'b1;
        c_in = (op == CFR_ALU_SBC) ? flags_in[CFR_BIT_C] : 1'b0;
        sum  = {1'b0, a} - {1'b0, b} - {8'h00, c_in};
        nib  = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, c_in};
      end
      CFR_ALU_INC: begin
        sum = {1'b0, a} + 9'h001;
        is_arith = 1'b0;
      end
      CFR_ALU_DEC: begin
        sum = {1'b0, a} - 9'h001;
        is_arith = 1'b0;
      end
      CFR_ALU_AND: begin
        sum = {1'b0, a & b};
        is_arith = 1'b0;
      end
      CFR_ALU_OR: begin
        sum = {1'b0, a | b};
        is_arith = 1'b0;
      end
      CFR_ALU_EOR: begin
        sum = {1'b0, a ^ b};
        is_arith = 1'b0;
      end
      default: begin
        sum = {1'b0, b};
        is_arith = 1'b0;
      end
    endcase
    result = sum[7:0];
  end

  always_comb begin
    flags_out = flags_in;
    n = result[7];
    case (op)
      CFR_ALU_ADD, CFR_ALU_ADC:
        v = (a[7] == b[7]) && (result[7] != a[7]);
      CFR_ALU_SUB, CFR_ALU_SBC:
        v = (a[7] != b[7]) && (result[7] != a[7]);
      CFR_ALU_INC: v = (result == 8'h80);
      CFR_ALU_DEC: v = (result == 8'h7f);
      default:     v = 1'b0;
    endcase
    if (op != CFR_ALU_MOV) begin
      if (is_arith) begin
        flags_out[CFR_BIT_H] = nib[4];
        flags_out[CFR_BIT_C] = sum[8];
      end
      flags_out[CFR_BIT_V] = v;
      flags_out[CFR_BIT_N] = n;
      flags_out[CFR_BIT_S] = n ^ v;
      // carried-in zero keeps multi-byte compares honest
      if (is_sub && c_in)
        flags_out[CFR_BIT_Z] = (result == 8'h00) & flags_in[CFR_BIT_Z];
      else
        flags_out[CFR_BIT_Z] = (result == 8'h00);
    end
    if (is_sub) flags_out[CFR_BIT_C] = sum[8];
  end
endmodule

// ---- cfr_core_state.sv ----
`timescale 1ns/1ps
// What this block does
// - ALU works on any of 32 registers, result written in one cycle.
// - flags are refreshed after every ALU operation except mov.
// - interrupt entry and return never save or restore the flags.
// - short I/O address equals data address minus 0x20, range 0x00-0x3F.
// - extended region from 0x60; short form past 0x3F is pinned to its base 0x60.
// - bit 7 global enable drives irq_enabled; irq_take acts whether or not it is set.
// - interrupt taken clears global enable; interrupt return sets it.
// - set/clear-enable instructions change bit 7 directly.
// - bit store copies register bit to bit 6; bit load copies back.
// - bit 5 holds half carry from nibble carry.
// - bit 4 sign equals negative xor overflow after every ALU operation except mov.
// - bit 3 holds two's complement overflow.
// - bits 2,1,0 hold negative, zero and carry.
// - file offers 8r/8w, 2x8r/8w, 2x8r/16w and 16r/16w schemes.
// - working registers also appear at data addresses 0 to 31.
// - registers 26-31 form three pointers with disp, inc, dec modes.
// - stack grows downward; pointer marks top of stack.
// - one-byte push decrements by one, pop increments by one.
// - calls and interrupt entry decrement by two; returns add two.
// - stack pointer resets to 0x8FF.
// - only stack pointer bits 11:0 writable; bits 15:12 read zero.
// - stack pointer low byte at 0x5D, high byte at 0x5E.
module cfr_core_state
  import cfr_pkg::*;
#(
  parameter int NREG = CFR_NREG
)(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic [4:0]  rd_a_sel,
  input  wire logic [4:0]  rd_b_sel,
  input  wire logic        alu_en,
  input  cfr_alu_op_t      alu_op,
  input  wire logic        alu_imm_sel,
  input  wire logic [7:0]  alu_imm,
  input  wire logic [4:0]  alu_dst,
  input  wire logic        wr8_en,
  input  wire logic [4:0]  wr8_sel,
  input  wire logic [7:0]  wr8_data,
  input  wire logic        wr16_en,
  input  wire logic [4:0]  wr16_sel,
  input  wire logic [15:0] wr16_data,
  input  wire logic        bit_store_insn,
  input  wire logic        bit_load_insn,
  input  wire logic [2:0]  bit_sel,
  input  wire logic        sei_insn,
  input  wire logic        cli_insn,
  input  wire logic        irq_take,
  input  wire logic        irq_return_insn,
  input  cfr_sp_op_t       sp_op,
  input  wire logic        ptr_en,
  input  wire logic [1:0]  ptr_sel,
  input  cfr_ptr_mode_t    ptr_mode,
  input  wire logic [5:0]  ptr_disp,
  input  wire logic        mem_rd,
  input  wire logic        mem_wr,
  input  wire logic        mem_io_form,
  input  wire logic [15:0] mem_addr,
  input  wire logic [7:0]  mem_wdata,
  output logic [7:0]       rd_a_data,
  output logic [7:0]       rd_b_data,
  output logic [15:0]      rd16_data,
  output logic [7:0]       cpu_flags,
  output logic [15:0]      stack_pointer_word,
  output logic             irq_enabled,
  output logic [15:0]      ptr_addr,
  output logic [7:0]       mem_rdata,
  output logic             mem_hit
);
  initial begin
    if (NREG != CFR_NREG) $error("register count must be 32");
  end

  logic [7:0]  regs [NREG];
  logic [7:0]  cpu_flags_reg;
  logic [15:0] sp_reg;
  logic [7:0]  alu_b;
  logic [7:0]  alu_res;
  logic [7:0]  alu_flags;
  logic [15:0] dmem_addr;
  logic [15:0] ptr_val;
  logic [15:0] ptr_next;
  logic [4:0]  ptr_base;
  logic        ptr_wb;
  logic        flags_hit;
  logic        spl_hit;
  logic        sph_hit;
  logic        reg_hit;
  logic [15:0] sp_next;
  logic [7:0]  flags_next;

  function automatic logic [4:0] ptr_reg_of(input logic [1:0] s);
    case (s)
      2'h0:    ptr_reg_of = CFR_PTR_X;
      2'h1:    ptr_reg_of = CFR_PTR_Y;
      default: ptr_reg_of = CFR_PTR_Z;
    endcase
  endfunction

  function automatic logic [15:0] pair_of(input logic [4:0] lo,
                                          input logic [7:0] l,
                                          input logic [7:0] h);
    pair_of = {h, l};
  endfunction

  assign alu_b = alu_imm_sel ? alu_imm : regs[rd_b_sel];

  cfr_alu u_alu (
    .op        (alu_op),
    .a         (regs[rd_a_sel]),
    .b         (alu_b),
    .flags_in  (cpu_flags_reg),
    .result    (alu_res),
    .flags_out (alu_flags)
  );

  // pointer formation: low byte from even register
  always_comb begin
    ptr_base = ptr_reg_of(ptr_sel);
    ptr_val  = pair_of(ptr_base, regs[ptr_base],
                       regs[ptr_base + 5'h01]);
    ptr_wb   = 1'b0;
    ptr_next = ptr_val;
    case (ptr_mode)
      CFR_PTR_DISP: ptr_next = ptr_val + {10'h000, ptr_disp};
      CFR_PTR_POSTINC: begin
        ptr_next = ptr_val + 16'h0001;
        ptr_wb   = ptr_en;
      end
      CFR_PTR_PREDEC: begin
        ptr_next = ptr_val - 16'h0001;
        ptr_wb   = ptr_en;
      end
      default: ptr_next = ptr_val;
    endcase
  end

  // effective data address; short form adds the I/O offset
  always_comb begin
    dmem_addr = mem_io_form ? (mem_addr + CFR_IO_OFFSET) : mem_addr;
    // short form past 0x3f is pinned to the extended base 0x60, where nothing decodes
    if (mem_io_form && mem_addr > CFR_IO_LAST)
      dmem_addr = CFR_EXT_IO_BASE;
    reg_hit   = (dmem_addr < 16'(NREG)) && !mem_io_form;
    flags_hit = (dmem_addr == CFR_FLAGS_ADDR);
    spl_hit   = (dmem_addr == CFR_SPL_ADDR);
    sph_hit   = (dmem_addr == CFR_SPL_ADDR + CFR_HI_STEP);
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NREG; i++) regs[i] <= 8'h00;
    end else begin
      if (wr16_en)
        {regs[wr16_sel + 5'h01], regs[wr16_sel]} <= wr16_data;
      if (wr8_en) regs[wr8_sel] <= wr8_data;
      if (alu_en) regs[alu_dst] <= alu_res;
      if (bit_load_insn)
        regs[alu_dst][bit_sel] <= cpu_flags_reg[CFR_BIT_T];
      if (ptr_wb)
        {regs[ptr_base + 5'h01], regs[ptr_base]} <= ptr_next;
      if (mem_wr && reg_hit) regs[dmem_addr[4:0]] <= mem_wdata;
    end
  end

  always_comb begin
    flags_next = cpu_flags_reg;
    if (alu_en) flags_next = alu_flags;
    if (bit_store_insn)
      flags_next[CFR_BIT_T] = regs[rd_a_sel][bit_sel];
    if (mem_wr && flags_hit) flags_next = mem_wdata;
    // interrupt entry/return touch only bit 7, never the rest
    if (sei_insn || irq_return_insn) flags_next[CFR_BIT_I] = 1'b1;
    if (cli_insn || irq_take) flags_next[CFR_BIT_I] = 1'b0;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) cpu_flags_reg <= CFR_FLAGS_RESET;
    else        cpu_flags_reg <= flags_next;
  end

  always_comb begin
    sp_next = sp_reg;
    case (sp_op)
      CFR_SP_PUSH1: sp_next = sp_reg - 16'h0001;
      CFR_SP_POP1:  sp_next = sp_reg + 16'h0001;
      CFR_SP_PUSH2: sp_next = sp_reg - 16'h0002;
      CFR_SP_POP2:  sp_next = sp_reg + 16'h0002;
      default:      sp_next = sp_reg;
    endcase
    if (mem_wr && spl_hit) sp_next[7:0] = mem_wdata;
    if (mem_wr && sph_hit) sp_next[15:8] = mem_wdata;
    sp_next = sp_next & CFR_SP_MASK;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) sp_reg <= CFR_SP_RESET;
    else        sp_reg <= sp_next;
  end

  // registered outputs follow the next state, so they match the state
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_flags          <= CFR_FLAGS_RESET;
      stack_pointer_word <= CFR_SP_RESET;
      irq_enabled        <= 1'b0;
    end else begin
      cpu_flags          <= flags_next;
      stack_pointer_word <= sp_next;
      irq_enabled        <= flags_next[CFR_BIT_I];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_a_data <= 8'h00;
      rd_b_data <= 8'h00;
      rd16_data <= 16'h0000;
      ptr_addr  <= 16'h0000;
    end else begin
      rd_a_data <= regs[rd_a_sel];
      rd_b_data <= regs[rd_b_sel];
      rd16_data <= {regs[rd_a_sel + 5'h01], regs[rd_a_sel]};
      // post-increment presents the old value, all other modes ptr_next
      ptr_addr  <= (ptr_mode == CFR_PTR_POSTINC) ? ptr_val : ptr_next;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_rdata <= 8'h00;
      mem_hit   <= 1'b0;
    end else begin
      mem_hit   <= (mem_rd || mem_wr)
                   && (reg_hit || flags_hit || spl_hit || sph_hit);
      if (!mem_rd)        mem_rdata <= 8'h00;
      else if (reg_hit)   mem_rdata <= regs[dmem_addr[4:0]];
      else if (flags_hit) mem_rdata <= cpu_flags_reg;
      else if (spl_hit)   mem_rdata <= sp_reg[7:0];
      else if (sph_hit)   mem_rdata <= sp_reg[15:8];
      else                mem_rdata <= 8'h00;
    end
  end
endmodule

// ---- cfr_core_state_asserts.sv ----
`timescale 1ns/1ps
module cfr_core_state_asserts
  import cfr_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        alu_en,
  input  cfr_alu_op_t      alu_op,
  input  wire logic        bit_store_insn,
  input  wire logic        cli_insn,
  input  wire logic        irq_take,
  input  wire logic        irq_return_insn,
  input  cfr_sp_op_t       sp_op,
  input  wire logic        mem_rd,
  input  wire logic        mem_wr,
  input  wire logic        mem_io_form,
  input  wire logic [15:0] mem_addr,
  input  wire logic [7:0]  cpu_flags,
  input  wire logic [15:0] stack_pointer_word,
  input  wire logic        irq_enabled,
  input  wire logic [7:0]  mem_rdata,
  input  wire logic        mem_hit
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // a byte write to the pointer in the same cycle overrides the step
  chk_sp_push_two: assert property (
    sp_op == CFR_SP_PUSH2 && !mem_wr |=> stack_pointer_word ==
      (($past(stack_pointer_word) - 16'h0002) & CFR_SP_MASK))
    else $error("stack pointer push2 step wrong");
  chk_sp_pop_one: assert property (
    sp_op == CFR_SP_POP1 && !mem_wr |=> stack_pointer_word ==
      (($past(stack_pointer_word) + 16'h0001) & CFR_SP_MASK))
    else $error("stack pointer pop1 step wrong");
  chk_sp_upper_zero: assert property (
    stack_pointer_word[15:12] == 4'h0)
    else $error("stack pointer upper bits not zero");
  // mov leaves the flags, so a raw write could still stand there
  chk_sign_flag_xor: assert property (
    alu_en && alu_op != CFR_ALU_MOV && !mem_wr && !bit_store_insn |=>
      cpu_flags[CFR_BIT_S] == (cpu_flags[CFR_BIT_N] ^ cpu_flags[CFR_BIT_V]))
    else $error("sign flag not n xor v");
  chk_irq_take_clear: assert property (
    irq_take |=> !irq_enabled ##0 !cpu_flags[CFR_BIT_I])
    else $error("global enable kept after interrupt");
  chk_irq_return_set: assert property (
    irq_return_insn && !cli_insn && !irq_take |=> irq_enabled)
    else $error("global enable not set on return");
  chk_irq_keep_flags: assert property (
    irq_take && !alu_en && !mem_wr && !bit_store_insn |=>
      (cpu_flags & 8'h7f) == ($past(cpu_flags) & 8'h7f))
    else $error("flags altered on interrupt entry");
  chk_io_upper_miss: assert property (
    mem_rd && mem_io_form && mem_addr > CFR_IO_LAST |=>
      !mem_hit && mem_rdata == 8'h00)
    else $error("short form reached beyond its range");
  chk_flags_data_read: assert property (
    mem_rd && !mem_io_form && mem_addr == CFR_FLAGS_ADDR |=>
      mem_hit && mem_rdata == $past(cpu_flags))
    else $error("flags read at data address wrong");
endmodule
bind cfr_core_state cfr_core_state_asserts u_chk (.*);

// ---- cfr_core_model.sv ----
`timescale 1ns/1ps
module cfr_core_model
  import cfr_pkg::*;
(
  input  wire logic  ref_clk,
  output logic [4:0] rd_a_sel,
  output logic [4:0] rd_b_sel,
  output logic       alu_en,
  output cfr_alu_op_t alu_op,
  output logic       alu_imm_sel,
  output logic [7:0] alu_imm,
  output logic [4:0] alu_dst,
  output logic       wr8_en,
  output logic [4:0] wr8_sel,
  output logic [7:0] wr8_data,
  output logic       wr16_en,
  output logic [4:0] wr16_sel,
  output logic [15:0] wr16_data,
  output logic       bit_store_insn,
  output logic       bit_load_insn,
  output logic [2:0] bit_sel,
  output logic       sei_insn,
  output logic       cli_insn,
  output logic       irq_take,
  output logic       irq_return_insn,
  output cfr_sp_op_t sp_op,
  output logic       ptr_en,
  output logic [1:0] ptr_sel,
  output cfr_ptr_mode_t ptr_mode,
  output logic [5:0] ptr_disp,
  output logic       mem_rd,
  output logic       mem_wr,
  output logic       mem_io_form,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata
);
  // pulses are dropped one falling edge after the taking edge
  task automatic go();
    @(posedge ref_clk);
    @(negedge ref_clk);
    {alu_en, wr8_en, wr16_en, bit_store_insn, bit_load_insn, sei_insn,
     cli_insn, irq_take, irq_return_insn, ptr_en, mem_rd, mem_wr} = '0;
    sp_op = CFR_SP_HOLD;
  endtask
  initial begin
    {rd_a_sel, rd_b_sel, alu_imm_sel, alu_imm, alu_dst, wr8_sel, wr8_data,
     wr16_sel, wr16_data, bit_sel, ptr_sel, ptr_disp, mem_io_form,
     mem_addr, mem_wdata} = '0;
    alu_op = CFR_ALU_ADD;
    ptr_mode = CFR_PTR_PLAIN;
    go();
  end
  task automatic alu(input cfr_alu_op_t op, input logic [4:0] a, b, d,
                     input logic s, input logic [7:0] i);
    @(negedge ref_clk);
    alu_op = op;
    {alu_en, rd_a_sel, rd_b_sel, alu_dst, alu_imm_sel, alu_imm} =
      {1'b1, a, b, d, s, i};
    go();
  endtask
  task automatic w8(input logic [4:0] s, input logic [7:0] d);
    @(negedge ref_clk);
    {wr8_en, wr8_sel, wr8_data} = {1'b1, s, d};
    go();
  endtask
  task automatic w16(input logic [4:0] s, input logic [15:0] d);
    @(negedge ref_clk);
    {wr16_en, wr16_sel, wr16_data} = {1'b1, s, d};
    go();
  endtask
  task automatic rd(input logic [4:0] a);
    @(negedge ref_clk);
    rd_a_sel = a;
    go();
  endtask
  task automatic mem(input logic io, w, input logic [15:0] a,
                     input logic [7:0] d);
    @(negedge ref_clk);
    {mem_rd, mem_wr, mem_io_form, mem_addr, mem_wdata} = {!w, w, io, a, d};
    go();
  endtask
  task automatic sp(input cfr_sp_op_t op);
    @(negedge ref_clk);
    sp_op = op;
    go();
  endtask
  // c: bit store, bit load, set enable, clear enable, take, return
  task automatic ctl(input logic [5:0] c, input logic [2:0] b);
    @(negedge ref_clk);
    {bit_store_insn, bit_load_insn, sei_insn, cli_insn, irq_take,
     irq_return_insn, bit_sel} = {c, b};
    go();
  endtask
  task automatic ptr(input logic [1:0] s, input cfr_ptr_mode_t md,
                     input logic [5:0] d);
    @(negedge ref_clk);
    ptr_mode = md;
    {ptr_en, ptr_sel, ptr_disp} = {1'b1, s, d};
    go();
  endtask
endmodule

// ---- testbench.sv ----
`timescale 1ns/1ps
module testbench
  import cfr_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] rd_a_sel, rd_b_sel, alu_dst, wr8_sel, wr16_sel;
  logic alu_en, alu_imm_sel, wr8_en, wr16_en, bit_store_insn, bit_load_insn;
  logic sei_insn, cli_insn, irq_take, irq_return_insn, ptr_en, mem_rd;
  logic mem_wr, mem_io_form, irq_enabled, mem_hit;
  logic [7:0] alu_imm, wr8_data, mem_wdata, rd_a_data, rd_b_data;
  logic [7:0] cpu_flags, mem_rdata;
  logic [15:0] wr16_data, mem_addr, rd16_data, stack_pointer_word, ptr_addr;
  logic [2:0] bit_sel;
  logic [1:0] ptr_sel;
  logic [5:0] ptr_disp;
  cfr_alu_op_t alu_op;
  cfr_sp_op_t sp_op;
  cfr_ptr_mode_t ptr_mode;
  int n_mismatch = 0;
  int checked = 0;
  cfr_sp_op_t sp_ops[4] = '{CFR_SP_PUSH2, CFR_SP_POP1, CFR_SP_PUSH1,
                            CFR_SP_POP2};
  logic [15:0] sp_exp[4] = '{16'h08fd, 16'h08fe, 16'h08fd, 16'h08ff};
  logic [5:0] irq_ops[4] = '{6'h08, 6'h02, 6'h01, 6'h04};
  logic [15:0] irq_exp[4] = '{16'h01f5, 16'h0075, 16'h01f5, 16'h0075};

  always #5 ref_clk = ~ref_clk;
  cfr_core_model m (.*);
  cfr_core_state DUT (.*);

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic summarize();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // no handshake to wait on, so a single watchdog bounds the whole run
  initial begin
    repeat (3000) @(posedge ref_clk);
    n_mismatch++;
    summarize();
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
    rst_n = 1'b1;
    chk(stack_pointer_word, 16'h08ff);
    m.mem(1'b0, 1'b0, CFR_FLAGS_ADDR, 8'h00);
    chk({7'h00, mem_hit, mem_rdata}, 16'h0100);
    m.w8(5'd1, 8'h7f);
    m.w8(5'd2, 8'h01);
    m.alu(CFR_ALU_ADD, 5'd1, 5'd2, 5'd3, 1'b0, 8'h00);
    chk({8'h00, cpu_flags}, 16'h002c);
    chk({8'h00, rd_b_data}, 16'h0001);
    m.rd(5'd3);
    chk({8'h00, rd_a_data}, 16'h0080);
    m.alu(CFR_ALU_ADD, 5'd3, 5'd0, 5'd3, 1'b1, 8'h80);
    chk({8'h00, cpu_flags}, 16'h001b);
    m.alu(CFR_ALU_SUB, 5'd3, 5'd0, 5'd3, 1'b1, 8'h01);
    chk({8'h00, cpu_flags}, 16'h0035);
    m.w16(CFR_PTR_X, 16'h1234);
    m.rd(CFR_PTR_X);
    chk(rd16_data, 16'h1234);
    chk({8'h00, rd_a_data}, 16'h0034);
    m.mem(1'b0, 1'b0, 16'h001b, 8'h00);
    chk({7'h00, mem_hit, mem_rdata}, 16'h0112);
    m.ptr(2'd0, CFR_PTR_POSTINC, 6'h00);
    chk(ptr_addr, 16'h1234);
    m.rd(CFR_PTR_X);
    chk(rd16_data, 16'h1235);
    m.ptr(2'd1, CFR_PTR_PREDEC, 6'h00);
    chk(ptr_addr, 16'hffff);
    m.ptr(2'd2, CFR_PTR_DISP, 6'h3f);
    chk(ptr_addr, 16'h003f);
    m.ctl(6'h20, 3'd1);
    m.alu(CFR_ALU_MOV, 5'd3, 5'd3, 5'd3, 1'b0, 8'h00);
    m.ctl(6'h10, 3'd7);
    m.rd(5'd3);
    chk({8'h00, rd_a_data}, 16'h007f);
    m.rd(CFR_PTR_X);
    m.ctl(6'h20, 3'd0);
    chk({8'h00, cpu_flags}, 16'h0075);
    for (int i = 0; i < 4; i++) begin
      m.ctl(irq_ops[i], 3'd0);
      chk({7'h00, irq_enabled, cpu_flags}, irq_exp[i]);
    end
    for (int i = 0; i < 4; i++) begin
      m.sp(sp_ops[i]);
      chk(stack_pointer_word, sp_exp[i]);
    end
    m.mem(1'b0, 1'b1, CFR_SPL_ADDR + CFR_HI_STEP, 8'hff);
    chk(stack_pointer_word, 16'h0fff);
    m.mem(1'b1, 1'b1, 16'h003d, 8'h00);
    chk(stack_pointer_word, 16'h0f00);
    m.mem(1'b1, 1'b0, 16'h003e, 8'h00);
    chk({7'h00, mem_hit, mem_rdata}, 16'h010f);
    m.mem(1'b1, 1'b0, CFR_IO_LAST, 8'h00);
    chk({7'h00, mem_hit, mem_rdata}, 16'h0175);
    m.mem(1'b1, 1'b0, 16'h0040, 8'h00);
    chk({7'h00, mem_hit, mem_rdata}, 16'h0000);
    // carry-in and keep-carry ops, starting from flags 0x75
    m.alu(CFR_ALU_ADC, 5'd1, 5'd2, 5'd4, 1'b0, 8'h00);
    chk({8'h00, cpu_flags}, 16'h006c);
    m.alu(CFR_ALU_SBC, 5'd2, 5'd1, 5'd5, 1'b0, 8'h00);
    chk({8'h00, cpu_flags}, 16'h0075);
    m.rd(5'd5);
    chk({8'h00, rd_a_data}, 16'h0082);
    m.alu(CFR_ALU_AND, 5'd1, 5'd0, 5'd6, 1'b1, 8'h80);
    chk({8'h00, cpu_flags}, 16'h0063);
    m.alu(CFR_ALU_INC, 5'd1, 5'd0, 5'd6, 1'b0, 8'h00);
    chk({8'h00, cpu_flags}, 16'h006d);
    m.alu(CFR_ALU_DEC, 5'd2, 5'd0, 5'd7, 1'b0, 8'h00);
    chk({8'h00, cpu_flags}, 16'h0063);
    m.alu(CFR_ALU_EOR, 5'd1, 5'd2, 5'd8, 1'b0, 8'h00);
    chk({8'h00, cpu_flags}, 16'h0061);
    summarize();
  end
endmodule
